// [core/dcf_fifo.sv]
// Single-clock 512 x 18 FIFO with full, empty, half and threshold flags and an AHB-Lite status port
`timescale 1ns/1ps

// Summary of operation
// - Without programming, both the almost-empty offset and the almost-full offset are 64.
// - The threshold flag is high when the word count is at most X or at least 512 minus Y.
// - The threshold flag is low when the word count lies from X plus 1 to 511 minus Y.
// - The active-low empty flag is low when no word is stored and after reset.
// - The active-low full flag is low when 512 words are stored and high after reset.
// - The half-full flag is high at 256 words or more and low after reset.
// - A load edge stores the input word only while the full flag is high.
// - An unload edge advances to the next word only while the empty flag is high.
// - The first word loaded into an empty buffer appears on the outputs at once.
// - The data outputs are released while the active-low output enable is high.
// - Reset clears the pointers, sets threshold and full flags high, half and empty low.
// - The first load edge after reset with program enable low sets X and Y from the low byte.
// - A second such edge with program enable still low sets only Y from the low byte.
// - Programming edges neither store a word nor change the word count.
module dcf_fifo #(
  parameter int DATA_W = dcf_pkg::DCF_DATA_W,
  parameter int PTR_W = dcf_pkg::DCF_PTR_W
) (
  input wire logic hclk, // System clock
  input wire logic hresetn, // Async reset, active low
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Transfer size
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready in
  output logic hreadyout, // Slave ready
  output logic hresp, // Response, always OKAY
  output logic [31:0] hrdata, // Read data
  output logic irq, // Level interrupt
  input wire logic load_clock, // Writer strobe, sampled
  input wire logic unload_clock, // Reader strobe, sampled
  input wire logic [DATA_W-1:0] write_data_in, // Word to load
  input wire logic offset_program_enable_n, // Offset programming, active low
  input wire logic output_enable_n, // Output enable, active low
  output logic [DATA_W-1:0] read_data_out, // Presented word
  output logic read_data_drive_n, // Low while outputs are driven
  output logic full_n, // Full, active low
  output logic empty_n, // Empty, active low
  output logic half_full_flag, // 256 words or more
  output logic almost_threshold_flag // Near empty or near full
);

  // Threshold test, used for the registered flag
  function automatic logic dcf_almost(input logic [9:0] cnt, input logic [7:0] x, input logic [7:0] y);
    logic [9:0] hi_mark;
    hi_mark = dcf_pkg::DCF_DEPTH - {2'b00, y};
    return (cnt <= {2'b00, x}) || (cnt >= hi_mark);
  endfunction

  logic [DATA_W-1:0] mem [0:(1<<PTR_W)-1];
  logic [PTR_W:0] wr_ptr_ff;
  logic [PTR_W:0] rd_ptr_ff;
  logic [PTR_W:0] nxt_wr_ptr;
  logic [PTR_W:0] nxt_rd_ptr;
  logic [9:0] count;
  logic [9:0] nxt_count;
  logic load_prev_ff;
  logic unload_prev_ff;
  logic load_rise;
  logic unload_rise;
  logic do_prog;
  logic do_load;
  logic do_unload;
  dcf_pkg::dcf_prog_t prog_ff;
  logic prog_open_ff;
  logic [7:0] x_ff;
  logic [7:0] y_ff;
  logic [7:0] nxt_x;
  logic [7:0] nxt_y;
  logic [DATA_W-1:0] data_q_ff;
  logic [dcf_pkg::DCF_EV_W-1:0] int_status_ff;
  logic [dcf_pkg::DCF_EV_W-1:0] int_mask_ff;
  logic [dcf_pkg::DCF_EV_W-1:0] events;
  logic [dcf_pkg::DCF_EV_W-1:0] w1c;
  logic wr_pend_ff;
  logic [7:0] wr_addr_ff;
  logic [31:0] hrdata_ff;
  logic [31:0] rd_mux;
  logic addr_phase;

  // Strobes arrive synchronous to hclk, so a plain edge detector suffices
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      load_prev_ff <= 1'b0;
      unload_prev_ff <= 1'b0;
    end
    else
    begin
      load_prev_ff <= load_clock;
      unload_prev_ff <= unload_clock;
    end
  end

  assign load_rise = load_clock & ~load_prev_ff;
  assign unload_rise = unload_clock & ~unload_prev_ff;
  assign count = 10'(wr_ptr_ff - rd_ptr_ff);

  // Classify each load edge as programming or data
  always_comb
  begin
    do_prog = load_rise && prog_open_ff && !offset_program_enable_n && (prog_ff != dcf_pkg::DCF_PROG_DONE);
    do_load = load_rise && !do_prog && full_n;
    do_unload = unload_rise && empty_n;
    nxt_wr_ptr = do_load ? (PTR_W+1)'(1) + wr_ptr_ff : wr_ptr_ff;
    nxt_rd_ptr = do_unload ? (PTR_W+1)'(1) + rd_ptr_ff : rd_ptr_ff;
    nxt_count = 10'(nxt_wr_ptr - nxt_rd_ptr);
    nxt_x = x_ff;
    nxt_y = y_ff;
    if (do_prog && prog_ff == dcf_pkg::DCF_PROG_FIRST)
    begin
      nxt_x = write_data_in[dcf_pkg::DCF_OFFSET_LSB +: dcf_pkg::DCF_OFFSET_W];
      nxt_y = write_data_in[dcf_pkg::DCF_OFFSET_LSB +: dcf_pkg::DCF_OFFSET_W];
    end
    else if (do_prog)
    begin
      nxt_y = write_data_in[dcf_pkg::DCF_OFFSET_LSB +: dcf_pkg::DCF_OFFSET_W];
    end
  end

  // Pointers; programming edges leave them alone
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end
    else
    begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
    end
  end

  // Offset programming window closes at the first stored word
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      prog_ff <= dcf_pkg::DCF_PROG_FIRST;
      prog_open_ff <= 1'b1;
      x_ff <= dcf_pkg::DCF_OFFSET_RST;
      y_ff <= dcf_pkg::DCF_OFFSET_RST;
    end
    else
    begin
      x_ff <= nxt_x;
      y_ff <= nxt_y;
      if (do_load)
      begin
        prog_open_ff <= 1'b0;
      end
      if (do_prog)
      begin
        case (prog_ff)
          dcf_pkg::DCF_PROG_FIRST: prog_ff <= dcf_pkg::DCF_PROG_SECOND;
          dcf_pkg::DCF_PROG_SECOND: prog_ff <= dcf_pkg::DCF_PROG_DONE;
          default: prog_ff <= dcf_pkg::DCF_PROG_DONE;
        endcase
      end
      else if (load_rise)
      begin
        prog_ff <= dcf_pkg::DCF_PROG_DONE; // A high enable ends the window for good
      end
    end
  end

  // Storage array, no reset needed
  always_ff @(posedge hclk)
  begin
    if (do_load)
    begin
      mem[wr_ptr_ff[PTR_W-1:0]] <= write_data_in;
    end
  end

  // Presented word: bypass when the buffer is or becomes empty ahead of the new word
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      data_q_ff <= '0;
    end
    else if (do_load && (count == 10'h000 || (do_unload && count == 10'h001)))
    begin
      data_q_ff <= write_data_in;
    end
    else if (do_unload && count > 10'h001)
    begin
      data_q_ff <= mem[rd_ptr_ff[PTR_W-1:0] + PTR_W'(1)];
    end
  end

  assign read_data_out = data_q_ff;
  assign read_data_drive_n = output_enable_n;

  // Flags registered from the next count so none can glitch
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      empty_n <= 1'b0;
      full_n <= 1'b1;
      half_full_flag <= 1'b0;
      almost_threshold_flag <= 1'b1;
    end
    else
    begin
      empty_n <= (nxt_count != 10'h000);
      full_n <= (nxt_count != dcf_pkg::DCF_DEPTH);
      half_full_flag <= (nxt_count >= dcf_pkg::DCF_HALF);
      almost_threshold_flag <= dcf_almost(nxt_count, nxt_x, nxt_y);
    end
  end

  // Events for the sticky interrupt status
  always_comb
  begin
    events = '0;
    events[dcf_pkg::DCF_EV_FULL] = full_n && (nxt_count == dcf_pkg::DCF_DEPTH);
    events[dcf_pkg::DCF_EV_EMPTY] = empty_n && (nxt_count == 10'h000);
    events[dcf_pkg::DCF_EV_OVERFLOW] = load_rise && !do_prog && !full_n;
    events[dcf_pkg::DCF_EV_UNDERFLOW] = unload_rise && !empty_n;
  end

  // AHB-Lite slave: zero wait, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;
  assign addr_phase = hsel && htrans[1] && hready;

  always_comb
  begin
    rd_mux = '0;
    case (haddr[7:0])
      dcf_pkg::DCF_REG_STATUS:
      begin
        rd_mux[dcf_pkg::DCF_ST_EMPTY_N] = empty_n;
        rd_mux[dcf_pkg::DCF_ST_FULL_N] = full_n;
        rd_mux[dcf_pkg::DCF_ST_HALF] = half_full_flag;
        rd_mux[dcf_pkg::DCF_ST_ALMOST] = almost_threshold_flag;
        rd_mux[dcf_pkg::DCF_ST_PROG_OPEN] = prog_open_ff;
      end
      dcf_pkg::DCF_REG_OFFSETS:
      begin
        rd_mux[dcf_pkg::DCF_OFS_X_LSB +: 8] = x_ff;
        rd_mux[dcf_pkg::DCF_OFS_Y_LSB +: 8] = y_ff;
      end
      dcf_pkg::DCF_REG_COUNT: rd_mux[9:0] = count;
      dcf_pkg::DCF_REG_INT_STATUS: rd_mux[dcf_pkg::DCF_EV_W-1:0] = int_status_ff;
      dcf_pkg::DCF_REG_INT_MASK: rd_mux[dcf_pkg::DCF_EV_W-1:0] = int_mask_ff;
      default: rd_mux = '0;
    endcase
  end

  // Read data sampled at the address phase; state may move one cycle before the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata_ff <= '0;
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= '0;
    end
    else
    begin
      wr_pend_ff <= addr_phase && hwrite;
      if (addr_phase)
      begin
        wr_addr_ff <= haddr[7:0];
        hrdata_ff <= hwrite ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  assign w1c = (wr_pend_ff && wr_addr_ff == dcf_pkg::DCF_REG_INT_STATUS) ? hwdata[dcf_pkg::DCF_EV_W-1:0] : '0;

  // Sticky status: a new event beats a same-cycle clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      int_status_ff <= '0;
      int_mask_ff <= dcf_pkg::DCF_INT_MASK_RST;
    end
    else
    begin
      int_status_ff <= (int_status_ff & ~w1c) | events;
      if (wr_pend_ff && wr_addr_ff == dcf_pkg::DCF_REG_INT_MASK)
      begin
        int_mask_ff <= hwdata[dcf_pkg::DCF_EV_W-1:0];
      end
    end
  end

  assign irq = |(int_status_ff & int_mask_ff);

endmodule

// [shared/dcf_pkg.sv]
// Constants for the single-clock 512 x 18 FIFO with programmable threshold flag
package dcf_pkg;
  // Storage geometry
  localparam int DCF_DATA_W = 18;
  localparam int DCF_PTR_W = 9;
  localparam logic [9:0] DCF_DEPTH = 10'h200;
  localparam logic [9:0] DCF_HALF = 10'h100;
  // Offset defaults and programming field
  localparam logic [7:0] DCF_OFFSET_RST = 8'h40;
  localparam int DCF_OFFSET_LSB = 0;
  localparam int DCF_OFFSET_W = 8;
  // Register byte offsets
  localparam logic [7:0] DCF_REG_STATUS = 8'h00;
  localparam logic [7:0] DCF_REG_OFFSETS = 8'h04;
  localparam logic [7:0] DCF_REG_COUNT = 8'h08;
  localparam logic [7:0] DCF_REG_INT_STATUS = 8'h0c;
  localparam logic [7:0] DCF_REG_INT_MASK = 8'h10;
  // Status register fields
  localparam int DCF_ST_EMPTY_N = 0;
  localparam int DCF_ST_FULL_N = 1;
  localparam int DCF_ST_HALF = 2;
  localparam int DCF_ST_ALMOST = 3;
  localparam int DCF_ST_PROG_OPEN = 4;
  // Offsets register fields
  localparam int DCF_OFS_X_LSB = 0;
  localparam int DCF_OFS_Y_LSB = 8;
  // Event bits, shared by interrupt status and mask
  localparam int DCF_EV_W = 4;
  localparam int DCF_EV_FULL = 0;
  localparam int DCF_EV_EMPTY = 1;
  localparam int DCF_EV_OVERFLOW = 2;
  localparam int DCF_EV_UNDERFLOW = 3;
  localparam logic [3:0] DCF_INT_MASK_RST = 4'h0;
  // Programming sequence
  typedef enum logic [1:0] {DCF_PROG_FIRST, DCF_PROG_SECOND, DCF_PROG_DONE} dcf_prog_t;
endpackage

// [tb/dcf_fifo_monitor.sv]
// Concurrent checks on the FIFO strobe and flag ports
`timescale 1ns/1ps
module dcf_fifo_monitor (
  input wire logic hclk, // Clock
  input wire logic hresetn, // Reset
  input wire logic load_clock, // Load
  input wire logic unload_clock, // Unload
  input wire logic [17:0] write_data_in, // Word in
  input wire logic offset_program_enable_n, // Program
  input wire logic output_enable_n, // Enable
  input wire logic [17:0] read_data_out, // Word out
  input wire logic read_data_drive_n, // Drive
  input wire logic full_n, // Full
  input wire logic empty_n, // Empty
  input wire logic half_full_flag, // Half
  input wire logic almost_threshold_flag // Threshold
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [1:0] n_prog_ff;
  // Programming edges since reset; bit 1 set once words may go to storage
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      n_prog_ff <= 2'h0;
    else if ($rose(load_clock))
      n_prog_ff <= (offset_program_enable_n || n_prog_ff[1]) ? 2'h3 : n_prog_ff + 2'h1;
  rst_flags_a: assert property (
    $rose(hresetn) |-> !empty_n && full_n && !half_full_flag && almost_threshold_flag)
    else $error("flags wrong after reset");
  empty_set_a: assert property (!empty_n |-> full_n && !half_full_flag && almost_threshold_flag)
    else $error("flags wrong while empty");
  full_set_a: assert property (!full_n |-> empty_n && half_full_flag && almost_threshold_flag)
    else $error("flags wrong while full");
  first_word_a: assert property (
    $rose(load_clock) && !empty_n && offset_program_enable_n |=> empty_n && read_data_out == $past(write_data_in))
    else $error("first word not presented");
  unload_empty_a: assert property (
    $rose(unload_clock) && !empty_n && !$rose(load_clock) |=> !empty_n && $stable(read_data_out))
    else $error("unload acted while empty");
  load_full_a: assert property (
    $rose(load_clock) && !full_n && !$rose(unload_clock) |=> !full_n && $stable(read_data_out))
    else $error("load acted while full");
  prog_hold_a: assert property (
    $rose(load_clock) && !offset_program_enable_n && !n_prog_ff[1] |=> !empty_n && $stable(read_data_out))
    else $error("programming edge stored a word");
  flags_hold_a: assert property (
    !$rose(load_clock) && !$rose(unload_clock) |=> $stable({empty_n, full_n, half_full_flag, almost_threshold_flag}))
    else $error("flag moved without a strobe");
  oe_release_a: assert property (read_data_drive_n == output_enable_n)
    else $error("output release does not follow enable");
endmodule

// [tb/dcf_fifo_tb_top.sv]
// Bench for the FIFO: offsets, flags, data order, release and interrupt
`timescale 1ns/1ps
bind dcf_fifo dcf_fifo_monitor mon_u (.hclk(hclk), .hresetn(hresetn), .load_clock(load_clock),
  .unload_clock(unload_clock), .write_data_in(write_data_in), .offset_program_enable_n(offset_program_enable_n),
  .output_enable_n(output_enable_n), .read_data_out(read_data_out), .read_data_drive_n(read_data_drive_n),
  .full_n(full_n), .empty_n(empty_n), .half_full_flag(half_full_flag), .almost_threshold_flag(almost_threshold_flag));
module dcf_fifo_tb_top;
  localparam int DEP = int'(dcf_pkg::DCF_DEPTH);
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, rq_l = 1'b0, rq_u = 1'b0, pen_n = 1'b1, oe_n = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  logic [17:0] wdata = 18'h0;
  wire [31:0] hrdata;
  wire [17:0] rdo;
  wire hrdy, hresp, irq, ldc, ulc, drv_n, full_n, empty_n, half, almost;
  int n_mismatch = 0, checked = 0;
  wire [31:0] flg = {28'h0, empty_n, full_n, half, almost};
  wire [17:0] q_bus = drv_n ? {18{1'bz}} : rdo; // Pin level as the reader sees it
  dcf_fifo dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy), .hresp(hresp), .hrdata(hrdata), .irq(irq),
    .load_clock(ldc), .unload_clock(ulc), .write_data_in(wdata), .offset_program_enable_n(pen_n),
    .output_enable_n(oe_n), .read_data_out(rdo), .read_data_drive_n(drv_n), .full_n(full_n),
    .empty_n(empty_n), .half_full_flag(half), .almost_threshold_flag(almost));
  dcf_strobe_model wr_u (.hclk(hclk), .hresetn(hresetn), .req_load(rq_l), .req_unload(rq_u),
    .load_clock(ldc), .unload_clock(ulc));
  initial forever #2 hclk = ~hclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    checked++;
    if (got !== want)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task automatic results;
    if (n_mismatch == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Single word transfer; an extra edge lets a write land before anything is looked at
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hrdy !== 1'b1);
    rd = hrdata;
    @(posedge hclk);
  endtask
  // One strobe rise; data held until captured, then turned over
  task automatic stb(input logic l, input logic u, input logic [17:0] d, input logic p);
    wdata <= d;
    pen_n <= p;
    rq_l <= l;
    rq_u <= u;
    @(posedge hclk);
    rq_l <= 1'b0;
    rq_u <= 1'b0;
    @(posedge hclk);
    wdata <= ~d; // Turned over after the capture edge, never in the caller's time step
    @(posedge hclk);
  endtask
  function automatic logic [31:0] fl(input int c, input int x, input int y);
    fl = {28'h0, c != 0, c != DEP, c >= int'(dcf_pkg::DCF_HALF), c <= x || c >= DEP - y};
  endfunction
  task automatic t_reset;
    hresetn <= 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk(flg, fl(0, 64, 64));
    ahb(1'b0, dcf_pkg::DCF_REG_OFFSETS, 32'h0);
    chk(rd, 32'h0000_4040);
    ahb(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, hresp}, 32'h0);
  endtask
  // Second edge carries upper data bits that must not reach the offset
  task automatic t_prog;
    stb(1'b1, 1'b0, 18'h0_0010, 1'b0);
    stb(1'b1, 1'b0, 18'h3_ff20, 1'b0);
    ahb(1'b0, dcf_pkg::DCF_REG_OFFSETS, 32'h0);
    chk(rd, 32'h0000_2010);
    ahb(1'b0, dcf_pkg::DCF_REG_COUNT, 32'h0);
    chk(rd, 32'h0);
    chk(flg, fl(0, 16, 32));
    ahb(1'b0, dcf_pkg::DCF_REG_STATUS, 32'h0);
    chk(rd, 32'h0000_001a);
  endtask
  task automatic t_fill(input int x, input int y);
    for (int i = 1; i <= DEP; i++)
    begin
      stb(1'b1, 1'b0, 18'(i), 1'b1);
      chk(flg, fl(i, x, y));
      if (i == 1)
        chk({14'h0, rdo}, 32'h0000_0001);
    end
    stb(1'b1, 1'b0, 18'h3_ffff, 1'b1);
    ahb(1'b0, dcf_pkg::DCF_REG_COUNT, 32'h0);
    chk(rd, 32'h0000_0200);
  endtask
  // Full is masked, overflow raises the line until cleared
  task automatic t_irq;
    chk({31'h0, irq}, 32'h0);
    ahb(1'b1, dcf_pkg::DCF_REG_INT_MASK, 32'h0000_000c);
    chk({31'h0, irq}, 32'h1);
    ahb(1'b1, dcf_pkg::DCF_REG_INT_STATUS, 32'h0000_0004);
    chk({31'h0, irq}, 32'h0);
    ahb(1'b0, dcf_pkg::DCF_REG_INT_STATUS, 32'h0);
    chk(rd, 32'h0000_0001);
  endtask
  task automatic t_drain(input int x, input int y);
    oe_n <= 1'b1;
    @(posedge hclk);
    chk({14'h0, q_bus}, {14'h0, {18{1'bz}}});
    oe_n <= 1'b0;
    @(posedge hclk);
    for (int i = 1; i <= DEP; i++)
    begin
      chk({14'h0, q_bus}, 32'(i));
      stb(1'b0, 1'b1, wdata, 1'b1);
      chk(flg, fl(DEP - i, x, y));
    end
    stb(1'b0, 1'b1, wdata, 1'b1);
    chk({14'h0, rdo}, 32'h0000_0200);
    chk({31'h0, irq}, 32'(x == 16));
  endtask
  initial
  begin
    t_reset();
    t_prog();
    t_fill(16, 32);
    t_irq();
    t_drain(16, 32);
    t_reset();
    t_fill(64, 64);
    t_drain(64, 64);
    results();
  end
  // Watchdog well above two fill and drain passes
  initial
  begin
    repeat (30000) @(posedge hclk);
    n_mismatch++;
    results();
  end
endmodule

// [tb/dcf_strobe_model.sv]
// Writer and reader strobe model for the load and unload inputs
`timescale 1ns/1ps
module dcf_strobe_model (
  input wire logic hclk, // Clock
  input wire logic hresetn, // Reset
  input wire logic req_load, // Load request
  input wire logic req_unload, // Unload request
  output logic load_clock, // Load strobe
  output logic unload_clock // Unload strobe
);
  // One-cycle strobes; a low cycle always follows so every rise is seen
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      load_clock <= 1'b0;
      unload_clock <= 1'b0;
    end
    else
    begin
      load_clock <= req_load && !load_clock;
      unload_clock <= req_unload && !unload_clock;
    end
endmodule
